// ---- ptwd_pkg.sv ----
// package: register map, field layout and constants of the timer capture select and watchdog block
package ptwd_pkg;
  // ==========================================================================
  // register byte addresses
  localparam logic [31:0] CAP_SRC_SEL_ADDR = 32'h40000014;
  localparam logic [31:0] TMR_INT_FLAGS_ADDR = 32'h42000088;
  localparam logic [31:0] WD_CONTROL_ADDR = 32'h42000090;
  localparam logic [31:0] WD_PRELOAD_ADDR = 32'h42000094;
  localparam logic [31:0] WD_STATUS_ADDR = 32'h42000098;
  localparam logic [31:0] WD_KEY_ADDR = 32'h4200009C;
  localparam logic [31:0] WD_DOWN_CNT_ADDR = 32'h420000A0;
  localparam logic [31:0] WD_INT_MASK_ADDR = 32'h420000A4;
  // ==========================================================================
  // field layout
  localparam int CAP0_LSB = 0;
  localparam int CAP1_LSB = 4;
  localparam int SEL_W = 3;
  localparam int NUM_EVT = 6;
  localparam int NUM_CAP = 2;
  localparam int NUM_FLAGS = 4;
  localparam int FLAG_CAP0 = 0;
  localparam int FLAG_CAP1 = 1;
  localparam int FLAG_WD_EXP = 2;
  localparam int FLAG_KEY_BAD = 3;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [2:0] SEL_MAX = 3'h5;
  // ==========================================================================
  // watchdog constants
  localparam logic [15:0] WD_KEY_FIRST = 16'hE51A;
  localparam logic [15:0] WD_KEY_SECOND = 16'hA35C;
  localparam logic [31:0] WD_ENABLE_CODE = 32'hA98559DA;
  localparam logic [31:0] WD_PRELOAD_RESET = 32'h00000FFF;
  localparam int WD_STAT_DIG = 1;
  localparam int WD_STAT_KEYSTATE = 0;
  localparam int WD_STAT_ANALOG = 2;
  localparam int WD_RESET_PULSE_CYC = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // key sequence state, gray coded
  typedef enum logic [0:0] {
    PTWD_KEY_IDLE = 1'b0,
    PTWD_KEY_ARMED = 1'b1
  } ptwd_key_t;
endpackage : ptwd_pkg

// ---- ptwd_timer_regs.sv ----
// module: capture source select, interrupt flags and digital watchdog registers on an axi4-lite slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
// Operation
// - capture 0 select field, reset zero
// - independent capture 1 select field, reset zero
// - codes 0..5 pick port tx/rx events
// - unused select bits: write zeros, read unspecified
// - readable pending timer interrupt flags
// - control register enables the watchdog
// - preload sets the down-counter reload value
// - key register services watchdog on correct sequence
// - status reports analog and digital watchdog
// - keys E51A then A35C before zero, else reset
// - watchdog off after reset until enabled
// - counters share clock, start separately, own prescale
module ptwd_timer_regs
  import ptwd_pkg::*;
(
  input wire logic core_clk, // block clock, 100 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [5:0] dmaEvents, // port tx/rx dma event lines, tx0 rx0 tx1 rx1 tx2 rx2
  input wire logic [1:0] captureFlagSet, // capture done pulses from the timer counters
  input wire logic analogWdFault, // analog watchdog state
  output logic [1:0] captureTrig, // selected capture triggers
  output logic wdResetReq, // processor reset request
  output logic irq // level interrupt
);

  // ==========================================================================
  // axi write and read channel state
  logic [31:0] awAddr_q;
  logic awHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHeld_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic arReady_q;
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  logic doWrite;
  logic doRead;
  logic wrHit;
  logic awReady_q;
  logic wReady_q;

  // ==========================================================================
  // register state
  logic [SEL_W-1:0] capSel_q [NUM_CAP];
  logic [NUM_FLAGS-1:0] intFlags_q;
  logic [NUM_FLAGS-1:0] intMask_q;
  logic [31:0] wdControl_q;
  logic [31:0] wdPreload_q;
  logic [31:0] wdCount_q;
  logic wdEnabled_q;
  logic wdExpired_q;
  ptwd_key_t keyState_q;
  logic [2:0] rstPulse_q;
  logic [1:0] captureTrig_q;
  logic irq_q;
  logic wdResetReq_q;
  logic [15:0] keyWord;
  logic keyWrite;
  logic keyService;
  logic keyBad;
  logic wdExpire;
  logic [NUM_FLAGS-1:0] flagEvents;
  logic [NUM_FLAGS-1:0] flagClear;
  logic [NUM_FLAGS-1:0] intFlags_d;
  logic [NUM_FLAGS-1:0] intMask_d;
  logic maskWrite;
  logic [31:0] wdStatus;

  // a write fires once address and data are both held and no response is pending
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign doRead = s_axi_arvalid && arReady_q && !rValid_q;

  // ==========================================================================
  // write channel
  // write address capture, taken in either order against data; ready is its own flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      awReady_q <= 1'b1;
      awAddr_q <= 32'h00000000;
    end else if (s_axi_awvalid && !awHeld_q) begin
      awHeld_q <= 1'b1;
      awReady_q <= 1'b0;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
      awReady_q <= 1'b1;
    end
  end

  // write data capture; ready is its own flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wHeld_q <= 1'b0;
      wReady_q <= 1'b1;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && !wHeld_q) begin
      wHeld_q <= 1'b1;
      wReady_q <= 1'b0;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
      wReady_q <= 1'b1;
    end
  end

  // write decode hit
  always_comb begin
    unique case (awAddr_q)
      CAP_SRC_SEL_ADDR, TMR_INT_FLAGS_ADDR, WD_CONTROL_ADDR, WD_PRELOAD_ADDR, WD_KEY_ADDR,
      WD_INT_MASK_ADDR: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // write response, slverr on unmapped or read-only address
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // read channel
  // read address ready, dropped while a read answer waits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      arReady_q <= 1'b0;
    end else begin
      arReady_q <= !rValid_q && !doRead;
    end
  end

  // read data mux; the counter read leaves the count untouched
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h00000000;
      rResp_q <= RESP_OKAY;
    end else if (doRead) begin
      rValid_q <= 1'b1;
      rResp_q <= RESP_OKAY;
      rData_q <= 32'h00000000; // unused bits read zero
      unique case (s_axi_araddr)
        CAP_SRC_SEL_ADDR: begin
          rData_q[CAP0_LSB +: SEL_W] <= capSel_q[0];
          rData_q[CAP1_LSB +: SEL_W] <= capSel_q[1];
        end
        TMR_INT_FLAGS_ADDR: rData_q[NUM_FLAGS-1:0] <= intFlags_q;
        WD_CONTROL_ADDR: rData_q <= wdControl_q;
        WD_PRELOAD_ADDR: rData_q <= wdPreload_q;
        WD_STATUS_ADDR: rData_q <= wdStatus;
        WD_DOWN_CNT_ADDR: rData_q <= wdCount_q;
        WD_INT_MASK_ADDR: rData_q[NUM_FLAGS-1:0] <= intMask_q;
        WD_KEY_ADDR: rData_q <= 32'h00000000;
        default: rResp_q <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // capture source selects, one per capture
  for (genvar c = 0; c < NUM_CAP; c++) begin : g_cap
    localparam int LSB = (c == 0) ? CAP0_LSB : CAP1_LSB;
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        capSel_q[c] <= SEL_RESET;
      end else if (doWrite && awAddr_q == CAP_SRC_SEL_ADDR && wStrb_q[0]) begin
        capSel_q[c] <= wData_q[LSB +: SEL_W]; // other bits dropped
      end
    end
    // reserved codes give no trigger; software keeps away from them
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        captureTrig_q[c] <= 1'b0;
      end else begin
        captureTrig_q[c] <= (capSel_q[c] <= SEL_MAX) && dmaEvents[capSel_q[c]];
      end
    end
  end

  // ==========================================================================
  // watchdog control; only the enable code turns it on, and only reset turns it off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdControl_q <= 32'h00000000;
      wdEnabled_q <= 1'b0;
    end else if (doWrite && awAddr_q == WD_CONTROL_ADDR && &wStrb_q) begin
      wdControl_q <= wData_q;
      if (wData_q == WD_ENABLE_CODE) begin
        wdEnabled_q <= 1'b1;
      end
    end
  end

  // preload holds the reload value; ignored once the watchdog runs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdPreload_q <= WD_PRELOAD_RESET;
    end else if (doWrite && awAddr_q == WD_PRELOAD_ADDR && &wStrb_q && !wdEnabled_q) begin
      wdPreload_q <= wData_q;
    end
  end

  // ==========================================================================
  // watchdog key sequence
  // key decode
  assign keyWord = wData_q[15:0];
  assign keyWrite = doWrite && awAddr_q == WD_KEY_ADDR && wStrb_q[1:0] == 2'h3;
  assign keyService = keyWrite && keyState_q == PTWD_KEY_ARMED && keyWord == WD_KEY_SECOND;
  assign keyBad = keyWrite && keyWord != WD_KEY_FIRST && keyWord != WD_KEY_SECOND;

  // two-step key sequence
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      keyState_q <= PTWD_KEY_IDLE;
    end else if (keyWrite) begin
      keyState_q <= (keyWord == WD_KEY_FIRST) ? PTWD_KEY_ARMED : PTWD_KEY_IDLE;
    end
  end

  // status word: key armed, digital expiry, analog watchdog state
  always_comb begin
    wdStatus = 32'h00000000;
    wdStatus[WD_STAT_KEYSTATE] = (keyState_q == PTWD_KEY_ARMED);
    wdStatus[WD_STAT_DIG] = wdExpired_q;
    wdStatus[WD_STAT_ANALOG] = analogWdFault;
  end

  // ==========================================================================
  // down-counter, reloaded from preload on service or while disabled
  assign wdExpire = wdEnabled_q && !wdExpired_q && wdCount_q == 32'h00000000 && !keyService;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdCount_q <= WD_PRELOAD_RESET;
    end else if (!wdEnabled_q || keyService) begin
      wdCount_q <= wdPreload_q;
    end else if (wdCount_q != 32'h00000000) begin
      wdCount_q <= wdCount_q - 32'h00000001;
    end
  end

  // expiry latch and processor reset pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdExpired_q <= 1'b0;
      rstPulse_q <= 3'h0;
      wdResetReq_q <= 1'b0;
    end else begin
      if (wdExpire) begin
        wdExpired_q <= 1'b1;
        rstPulse_q <= 3'(WD_RESET_PULSE_CYC);
      end else if (rstPulse_q != 3'h0) begin
        rstPulse_q <= rstPulse_q - 3'h1;
      end
      wdResetReq_q <= wdExpire || rstPulse_q > 3'h1;
    end
  end

  // ==========================================================================
  // interrupt flags: sticky, write one to clear, set wins
  assign flagEvents[FLAG_CAP0] = captureFlagSet[0]; // captures come from the timer counters
  assign flagEvents[FLAG_CAP1] = captureFlagSet[1];
  assign flagEvents[FLAG_WD_EXP] = wdExpire;
  assign flagEvents[FLAG_KEY_BAD] = keyBad;
  assign flagClear = (doWrite && awAddr_q == TMR_INT_FLAGS_ADDR && wStrb_q[0]) ?
                     wData_q[NUM_FLAGS-1:0] : '0;
  assign maskWrite = doWrite && awAddr_q == WD_INT_MASK_ADDR && wStrb_q[0];

  // next flag and mask values, shared with the interrupt output so it never lags a write
  assign intFlags_d = (intFlags_q & ~flagClear) | flagEvents; // set wins over clear
  assign intMask_d = maskWrite ? wData_q[NUM_FLAGS-1:0] : intMask_q;

  // sticky flags
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      intFlags_q <= '0;
    end else begin
      intFlags_q <= intFlags_d;
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      intMask_q <= '0;
    end else begin
      intMask_q <= intMask_d;
    end
  end

  // interrupt output, high while an unmasked flag is set
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(intFlags_d & intMask_d);
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign captureTrig = captureTrig_q;
  assign wdResetReq = wdResetReq_q;
  assign irq = irq_q;

endmodule : ptwd_timer_regs

// ---- ptwd_dma_src.sv ----
// partner model: port dma event sources that feed the capture selectors
`timescale 1ns/100ps
module ptwd_dma_src (
  input wire logic core_clk, // block clock
  input wire logic [5:0] fireMask, // events to raise, tx0 rx0 tx1 rx1 tx2 rx2
  output logic [5:0] dmaEvents // event lines into the block
);
  // ==========================================================================
  // events leave on the clock edge, one line per port and direction
  always_ff @(posedge core_clk) begin
    dmaEvents <= fireMask;
  end
endmodule : ptwd_dma_src

// ---- ptwd_timer_regs_checker.sv ----
// checker: port-level assertions of the capture select and watchdog block
`timescale 1ns/100ps
module ptwd_timer_regs_checker
  import ptwd_pkg::*;
(
  input wire logic core_clk, // block clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [5:0] dmaEvents, // event lines
  input wire logic [1:0] captureTrig, // capture triggers
  input wire logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic wdResetReq, // reset request
  input wire logic irq // level interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // reset request: four cycles high, then low
  sequence resetTrain_s; wdResetReq [*4] ##1 !wdResetReq; endsequence
  chk_trig_cause: assert property (captureTrig != 2'h0 |-> $past(dmaEvents) != 6'h00)
    else $error("trigger without an event");
  chk_trig_quiet: assert property (dmaEvents == 6'h00 |=> captureTrig == 2'h0)
    else $error("trigger stays up without events");
  chk_reset_quiet: assert property ($rose(rst_n) |-> !wdResetReq && !irq && !s_axi_bvalid)
    else $error("outputs active after reset");
  chk_dog_pulse: assert property ($rose(wdResetReq) |-> resetTrain_s)
    else $error("reset request length wrong");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answering");
endmodule : ptwd_timer_regs_checker
bind ptwd_timer_regs ptwd_timer_regs_checker chk_u (.*);

// ---- test_timer_capture_select_watchdog_regs.sv ----
// testbench: capture routing, interrupt flags and watchdog over the register bus
`timescale 1ns/100ps
module test_timer_capture_select_watchdog_regs
  import ptwd_pkg::*;
;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdResetReq, irq;
  logic analogWdFault = 1'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, captureTrig, rsp, captureFlagSet = 2'h0;
  logic [5:0] dmaEvents, fireMask = 6'h00;
  // rows: capture1 select, capture0 select, events, expected triggers
  logic [13:0] rows [6] = '{{3'h5, 3'h0, 6'h01, 2'h1}, {3'h4, 3'h1, 6'h12, 2'h3}, {3'h3, 3'h2, 6'h04, 2'h1},
    {3'h2, 3'h3, 6'h0C, 2'h3}, {3'h1, 3'h4, 6'h20, 2'h0}, {3'h0, 3'h5, 6'h01, 2'h2}};
  int failures = 0, samples_checked = 0, cycles = 0;
  ptwd_timer_regs dut_u (.*);
  ptwd_dma_src src_u (.*);
  // ==========================================================================
  // clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  // ==========================================================================
  // compare, bus and closing tasks
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, d);
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rdc(input logic [31:0] a, exp);
    @(posedge core_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    {rdv, rsp} = {s_axi_rdata, s_axi_rresp};
    chk(rdv, exp);
  endtask : rdc
  task automatic summarize;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'h1;
    rdc(CAP_SRC_SEL_ADDR, 32'h0);
    rdc(WD_PRELOAD_ADDR, WD_PRELOAD_RESET);
    rdc(WD_STATUS_ADDR, 32'h0);
    // routing table: both selectors through every code 0..5
    foreach (rows[i]) begin
      wr(CAP_SRC_SEL_ADDR, {25'h0, rows[i][13:11], 1'h0, rows[i][10:8]}); // codes kept to 0..5
      rdc(CAP_SRC_SEL_ADDR, {25'h0, rows[i][13:11], 1'h0, rows[i][10:8]});
      fireMask <= rows[i][7:2];
      repeat (3) @(posedge core_clk);
      chk({30'h0, captureTrig}, {30'h0, rows[i][1:0]});
    end
    fireMask <= 6'h00;
    // refused places: unmapped read, write to a read-only register
    rdc(32'h42000004, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(WD_STATUS_ADDR, 32'hFFFFFFFF);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // capture flags: raise, mask, clear
    wr(WD_INT_MASK_ADDR, 32'h1);
    captureFlagSet <= 2'h3;
    @(posedge core_clk);
    captureFlagSet <= 2'h0;
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    rdc(TMR_INT_FLAGS_ADDR, 32'h3);
    wr(TMR_INT_FLAGS_ADDR, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(TMR_INT_FLAGS_ADDR, 32'h2);
    wr(TMR_INT_FLAGS_ADDR, 32'h2);
    // watchdog: preload, enable, service, then starve it
    analogWdFault <= 1'h1;
    wr(WD_PRELOAD_ADDR, 32'h40);
    rdc(WD_DOWN_CNT_ADDR, 32'h40);
    wr(WD_CONTROL_ADDR, WD_ENABLE_CODE);
    rdc(WD_CONTROL_ADDR, WD_ENABLE_CODE);
    repeat (6) begin
      wr(WD_KEY_ADDR, {16'h0, WD_KEY_FIRST});
      rdc(WD_STATUS_ADDR, 32'h5);
      wr(WD_KEY_ADDR, {16'h0, WD_KEY_SECOND});
    end
    chk({31'h0, wdResetReq}, 32'h0);
    wr(WD_KEY_ADDR, 32'h1234);
    repeat (200) begin
      if (!wdResetReq) @(posedge core_clk);
    end
    chk({31'h0, wdResetReq}, 32'h1);
    rdc(WD_STATUS_ADDR, 32'h6);
    rdc(TMR_INT_FLAGS_ADDR, 32'hC);
    // reset in mid-run: selects, expiry, enable and flags all clear, watchdog stays off
    rst_n <= 1'h0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'h1;
    rdc(CAP_SRC_SEL_ADDR, 32'h0);
    rdc(WD_STATUS_ADDR, 32'h4);
    rdc(TMR_INT_FLAGS_ADDR, 32'h0);
    rdc(WD_CONTROL_ADDR, 32'h0);
    repeat (20) @(posedge core_clk);
    rdc(WD_DOWN_CNT_ADDR, WD_PRELOAD_RESET);
    chk({31'h0, wdResetReq}, 32'h0);
    summarize();
  end
endmodule : test_timer_capture_select_watchdog_regs
